// ### core/fwes_pkg.sv
// constants and types shared by the flash write/erase sequencer
package fwes_pkg;

	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int PROG_TIME_NS  = 40;
	localparam int PROG_CYCLES   =
		(PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// memory geometry
	localparam int FLASH_AW      = 16;
	localparam int PAGE_AW       = 10;
	localparam int PAGE_BYTES    = 1024;
	localparam int SCRATCH_BYTES = 1024;

	localparam logic [FLASH_AW-1:0] SHORT_ADDR_MAX = 16'h00FF;
	localparam logic [FLASH_AW-1:0] SCRATCH_LAST   = 16'h03FF;
	localparam logic [7:0]          ERASED_BYTE    = 8'hFF;

	// unlock codes, first then second
	localparam logic [7:0] KEY_FIRST  = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'hF1;

	// register byte offsets on the bus
	localparam logic [7:0] PSC_OFS    = 8'h00;
	localparam logic [7:0] KEY_OFS    = 8'h04;
	localparam logic [7:0] SUPPLY_OFS = 8'h08;
	localparam logic [7:0] RSRC_OFS   = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;

	// field positions
	localparam int PSC_WE_BIT     = 0;
	localparam int PSC_EE_BIT     = 1;
	localparam int PSC_SCR_BIT    = 2;
	localparam int SUP_EN_BIT     = 0;
	localparam int SUP_RST_BIT    = 1;
	localparam int RSRC_FERR_BIT  = 0;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DEAD_BIT  = 1;
	localparam int KEY_STATE_LSB  = 0;

	// reset values and unmapped read data
	localparam logic       PSC_RESET     = 1'b0;
	localparam logic       SUPPLY_RESET  = 1'b1;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	typedef enum logic [1:0] {
		KEY_LOCKED,
		KEY_HALF,
		KEY_OPEN,
		KEY_DEAD
	} fwes_key_e;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_PROG,
		OP_ERASE
	} fwes_op_e;

	// external data move request from the core
	typedef struct packed {
		logic                we;
		logic                short_addr;
		logic [FLASH_AW-1:0] addr;
		logic [7:0]          data;
	} fwes_xd_s;

	// two-wire debug programming request
	typedef struct packed {
		logic                erase;
		logic [FLASH_AW-1:0] addr;
		logic [7:0]          data;
	} fwes_dbg_s;

	// forwarded data ram access
	typedef struct packed {
		logic                req;
		logic                we;
		logic [FLASH_AW-1:0] addr;
		logic [7:0]          data;
	} fwes_ram_s;

endpackage

// ### core/fwes_top.sv
// flash write/erase sequencer with key lock, scratchpad and bus registers
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns

module fwes_top (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       por_i,
	// classic wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [7:0]                 wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	// core data moves
	input  wire logic                       xd_req_i,
	input  wire fwes_pkg::fwes_xd_s         xd_i,
	output fwes_pkg::fwes_ram_s             ram_o,
	output logic                            cpu_stall_o,
	// code reads and instruction fetch
	input  wire logic                       code_rd_i,
	input  wire logic                       code_fetch_i,
	input  wire logic [fwes_pkg::FLASH_AW-1:0] code_addr_i,
	output logic      [7:0]                 code_rdata_o,
	output logic                            code_valid_o,
	// debug programming port
	input  wire logic                       dbg_req_i,
	input  wire fwes_pkg::fwes_dbg_s        dbg_i,
	output logic                            dbg_done_o,
	// request for a flash error device reset
	output logic                            fault_reset_o
);

	localparam int FLASH_BYTES = 1 << fwes_pkg::FLASH_AW;
	localparam logic [fwes_pkg::PAGE_AW-1:0] PROG_LAST =
		fwes_pkg::PAGE_AW'(fwes_pkg::PROG_CYCLES - 1);
	localparam logic [fwes_pkg::PAGE_AW-1:0] ERASE_LAST =
		fwes_pkg::PAGE_AW'(fwes_pkg::PAGE_BYTES - 1);

	// nonvolatile arrays; contents survive every reset
	logic [7:0] flash_mem   [0:FLASH_BYTES-1];
	logic [7:0] scratch_mem [0:fwes_pkg::SCRATCH_BYTES-1];

	function automatic logic in_scratch(
		input logic                          sel,
		input logic [fwes_pkg::FLASH_AW-1:0] a
	);
		in_scratch = sel && (a <= fwes_pkg::SCRATCH_LAST);
	endfunction

	// control registers
	logic                store_write_enable;
	logic                store_erase_enable;
	logic                scratchpad_select;
	logic                mon_enable;
	logic                mon_reset_enable;
	logic                flash_error_flag;
	logic                err_pending;
	logic                rst_seen;
	fwes_pkg::fwes_key_e key_state;
	fwes_pkg::fwes_key_e next_key;

	// operation sequencer
	fwes_pkg::fwes_op_e            op;
	fwes_pkg::fwes_op_e            next_op;
	logic [fwes_pkg::PAGE_AW-1:0]  cnt;
	logic [fwes_pkg::FLASH_AW-1:0] op_addr;
	logic [7:0]                    op_data;
	logic                          op_scr;
	logic                          op_cpu;

	wire logic any_rst = rst_i || por_i;

	// bus decode
	wire logic wb_req   = wb_cyc_i && wb_stb_i;
	wire logic wb_wr    = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
	wire logic wr_psc   = wb_wr && (wb_adr_i == fwes_pkg::PSC_OFS);
	wire logic wr_key   = wb_wr && (wb_adr_i == fwes_pkg::KEY_OFS);
	wire logic wr_sup   = wb_wr && (wb_adr_i == fwes_pkg::SUPPLY_OFS);
	wire logic [7:0] wb_byte = wb_dat_i[7:0];

	// core request decode
	wire logic idle       = (op == fwes_pkg::OP_IDLE);
	wire logic xd_take    = xd_req_i && idle;
	wire logic flash_wr   = xd_take && xd_i.we
		&& store_write_enable;
	wire logic supply_ok  = mon_enable && mon_reset_enable;
	wire logic fault      = flash_wr && !supply_ok;
	wire logic unlocked   = (key_state == fwes_pkg::KEY_OPEN);
	wire logic key_fail   = flash_wr && supply_ok && !unlocked;
	wire logic cpu_start  = flash_wr && supply_ok && unlocked;
	wire logic ram_access = xd_take && !flash_wr;

	// 8-bit flash writes see only the low 256 bytes, ram forwarding takes the full address
	wire logic [fwes_pkg::FLASH_AW-1:0] xd_target = xd_i.short_addr
		? (xd_i.addr & fwes_pkg::SHORT_ADDR_MAX)
		: xd_i.addr;

	// debug port only when the core is not asking this cycle
	wire logic dbg_take   = dbg_req_i && idle && !xd_req_i;
	wire logic start_erase = (cpu_start && store_erase_enable)
		|| (dbg_take && dbg_i.erase);
	wire logic start_prog  = (cpu_start && !store_erase_enable)
		|| (dbg_take && !dbg_i.erase);
	wire logic [fwes_pkg::FLASH_AW-1:0] start_addr =
		cpu_start ? xd_target : dbg_i.addr;
	wire logic [7:0] start_data = cpu_start ? xd_i.data : dbg_i.data;

	wire logic prog_done  = (op == fwes_pkg::OP_PROG) && (cnt == PROG_LAST);
	wire logic erase_done = (op == fwes_pkg::OP_ERASE)
		&& (cnt == ERASE_LAST);
	wire logic op_done    = prog_done || erase_done;

	// memory write port
	wire logic [fwes_pkg::FLASH_AW-1:0] erase_addr =
		{op_addr[fwes_pkg::FLASH_AW-1:fwes_pkg::PAGE_AW], cnt};
	wire logic mem_we = prog_done || (op == fwes_pkg::OP_ERASE);
	wire logic mem_erase = (op == fwes_pkg::OP_ERASE);
	wire logic [fwes_pkg::FLASH_AW-1:0] mem_addr =
		mem_erase ? erase_addr : op_addr;

	// bus read mux
	wire logic [7:0] rd_psc = {5'h00, scratchpad_select,
		store_erase_enable, store_write_enable};
	wire logic [7:0] rd_key = {6'h00, key_state};
	wire logic [7:0] rd_sup = {6'h00, mon_reset_enable, mon_enable};
	wire logic [7:0] rd_rsrc = {7'h00, flash_error_flag};
	wire logic [7:0] rd_stat = {6'h00,
		(key_state == fwes_pkg::KEY_DEAD), cpu_stall_o};
	wire logic [7:0] rd_byte =
		(wb_adr_i == fwes_pkg::PSC_OFS)    ? rd_psc  :
		(wb_adr_i == fwes_pkg::KEY_OFS)    ? rd_key  :
		(wb_adr_i == fwes_pkg::SUPPLY_OFS) ? rd_sup  :
		(wb_adr_i == fwes_pkg::RSRC_OFS)   ? rd_rsrc :
		(wb_adr_i == fwes_pkg::STATUS_OFS) ? rd_stat :
		fwes_pkg::RDATA_UNMAPPED;

	// key lock transitions
	always_comb begin
		next_key = key_state;
		if (wr_key) begin
			case (key_state)
			fwes_pkg::KEY_LOCKED: begin
				next_key = (wb_byte == fwes_pkg::KEY_FIRST)
					? fwes_pkg::KEY_HALF
					: fwes_pkg::KEY_DEAD;
			end
			fwes_pkg::KEY_HALF: begin
				next_key = (wb_byte == fwes_pkg::KEY_SECOND)
					? fwes_pkg::KEY_OPEN
					: fwes_pkg::KEY_DEAD;
			end
			fwes_pkg::KEY_OPEN: begin
				next_key = fwes_pkg::KEY_DEAD;
			end
			default: begin
				next_key = fwes_pkg::KEY_DEAD;
			end
			endcase
		end
		// dead wins over everything until reset
		if (key_state == fwes_pkg::KEY_DEAD || key_fail) begin
			next_key = fwes_pkg::KEY_DEAD;
		end else if (op_done && op_cpu) begin
			next_key = fwes_pkg::KEY_LOCKED;
		end else if (cpu_start) begin
			next_key = fwes_pkg::KEY_OPEN;
		end
	end

	// sequencer transitions
	always_comb begin
		next_op = op;
		case (op)
		fwes_pkg::OP_IDLE: begin
			if (start_erase) begin
				next_op = fwes_pkg::OP_ERASE;
			end else if (start_prog) begin
				next_op = fwes_pkg::OP_PROG;
			end
		end
		fwes_pkg::OP_PROG,
		fwes_pkg::OP_ERASE: begin
			if (op_done) begin
				next_op = fwes_pkg::OP_IDLE;
			end
		end
		default: begin
			next_op = fwes_pkg::OP_IDLE;
		end
		endcase
	end

	// wishbone answer: ack one cycle after the request, dropped next
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			wb_dat_o <= {24'h000000, rd_byte};
		end
	end

	// program store control; hardware never clears write enable
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			store_write_enable <= fwes_pkg::PSC_RESET;
			store_erase_enable <= fwes_pkg::PSC_RESET;
			scratchpad_select  <= fwes_pkg::PSC_RESET;
		end else if (wr_psc) begin
			store_write_enable <= wb_byte[fwes_pkg::PSC_WE_BIT];
			store_erase_enable <= wb_byte[fwes_pkg::PSC_EE_BIT];
			scratchpad_select  <= wb_byte[fwes_pkg::PSC_SCR_BIT];
		end
	end

	// supply monitor settings survive system reset, set by power-on
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			mon_enable       <= fwes_pkg::SUPPLY_RESET;
			mon_reset_enable <= fwes_pkg::SUPPLY_RESET;
		end else if (wr_sup) begin
			mon_enable       <= wb_byte[fwes_pkg::SUP_EN_BIT];
			mon_reset_enable <= wb_byte[fwes_pkg::SUP_RST_BIT];
		end
	end

	// error flag records whether the last system reset was ours
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			flash_error_flag <= 1'b0;
			err_pending      <= 1'b0;
			fault_reset_o    <= 1'b0;
			rst_seen         <= 1'b1;
		end else if (rst_i) begin
			// capture once, a long reset must not wipe the flag
			if (!rst_seen) begin
				flash_error_flag <= err_pending;
			end
			err_pending      <= 1'b0;
			fault_reset_o    <= 1'b0;
			rst_seen         <= 1'b1;
		end else begin
			err_pending   <= err_pending || fault;
			fault_reset_o <= fault || err_pending;
			rst_seen      <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			key_state <= fwes_pkg::KEY_LOCKED;
		end else begin
			key_state <= next_key;
		end
	end

	// core stays stalled for the whole timed operation
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			op          <= fwes_pkg::OP_IDLE;
			cpu_stall_o <= 1'b0;
			cnt         <= '0;
			op_addr     <= '0;
			op_data     <= '0;
			op_scr      <= 1'b0;
			op_cpu      <= 1'b0;
			dbg_done_o  <= 1'b0;
		end else begin
			op          <= next_op;
			cpu_stall_o <= (next_op != fwes_pkg::OP_IDLE);
			dbg_done_o  <= op_done && !op_cpu;
			if (idle) begin
				cnt     <= '0;
				op_addr <= start_addr;
				op_data <= start_data;
				op_scr  <= in_scratch(scratchpad_select,
					start_addr);
				op_cpu  <= cpu_start;
			end else begin
				cnt <= op_done ? '0 : cnt + 1'b1;
			end
		end
	end

	// flash array: erase walks the page, program only clears bits
	always_ff @(posedge clk_i) begin
		if (mem_we && !op_scr) begin
			flash_mem[mem_addr] <= mem_erase ? fwes_pkg::ERASED_BYTE
				: (flash_mem[mem_addr] & op_data);
		end
	end

	// scratchpad is one page, so a page erase clears all of it
	always_ff @(posedge clk_i) begin
		if (mem_we && op_scr) begin
			scratch_mem[mem_addr[fwes_pkg::PAGE_AW-1:0]] <= mem_erase
				? fwes_pkg::ERASED_BYTE
				: (scratch_mem[mem_addr[fwes_pkg::PAGE_AW-1:0]]
				& op_data);
		end
	end

	// data ram forwarding; reads and unenabled writes land here
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			ram_o <= '0;
		end else begin
			ram_o.req  <= ram_access;
			ram_o.we   <= ram_access && xd_i.we;
			ram_o.addr <= xd_i.addr;
			ram_o.data <= xd_i.data;
		end
	end

	// code reads may see the scratchpad, instruction fetch never does
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			code_rdata_o <= '0;
			code_valid_o <= 1'b0;
		end else begin
			code_valid_o <= code_rd_i;
			if (code_rd_i) begin
				code_rdata_o <= (!code_fetch_i
					&& in_scratch(scratchpad_select, code_addr_i))
					? scratch_mem[code_addr_i[fwes_pkg::PAGE_AW-1:0]]
					: flash_mem[code_addr_i];
			end
		end
	end

endmodule // fwes_top

// ### sim/fwes_core_model.sv
// behavioural core issuing one data move per go pulse
`timescale 1ns/1ns
module fwes_core_model (
	input  wire logic               clk_i,
	input  wire logic               cpu_stall_i,
	input  wire logic               go_i,
	input  wire fwes_pkg::fwes_xd_s cmd_i,
	output logic                    xd_req_o,
	output fwes_pkg::fwes_xd_s      xd_o
);
	logic pend = 1'b0;

	initial xd_req_o = 1'b0;

	// a stalled core cannot issue; one move per masked sequence
	always @(posedge clk_i) begin
		if (go_i)
			pend <= 1'b1;
		xd_req_o <= 1'b0;
		if (pend && !cpu_stall_i && !xd_req_o) begin
			xd_req_o <= 1'b1;
			pend <= 1'b0;
		end
	end

	// idle lines carry junk, not the last move
	assign xd_o = xd_req_o ? cmd_i : ~cmd_i;
endmodule // fwes_core_model

// ### sim/fwes_monitor.sv
// port timing checker for the flash write/erase sequencer
`timescale 1ns/1ns
module fwes_monitor (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                por_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_ack_o,
	input  wire logic                xd_req_i,
	input  wire fwes_pkg::fwes_xd_s  xd_i,
	input  wire fwes_pkg::fwes_ram_s ram_o,
	input  wire logic                cpu_stall_o,
	input  wire logic                code_rd_i,
	input  wire logic                code_valid_o,
	input  wire logic                dbg_req_i,
	input  wire logic                fault_reset_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);

	// stall length counted here; a delay range this long unrolls slowly
	logic [10:0] stall_run;

	always_ff @(posedge clk_i) begin
		if (rst_i || por_i || !cpu_stall_o) begin
			stall_run <= 11'h000;
		end else if (stall_run != 11'h7FF) begin
			stall_run <= stall_run + 11'h001;
		end
	end

	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("bus request not acked next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_stall_min: assert property ($rose(cpu_stall_o) |-> cpu_stall_o[*8])
		else $error("stall shorter than an operation");
	a_stall_end: assert property (stall_run < 11'h406)
		else $error("stall never released");
	a_stall_cause: assert property ($rose(cpu_stall_o)
		|-> $past(xd_req_i && xd_i.we) || $past(dbg_req_i))
		else $error("stall without a write request");
	a_ram_read: assert property (xd_req_i && !xd_i.we && !xd_i.short_addr
		&& !cpu_stall_o |=> ram_o.req && !ram_o.we
		&& ram_o.addr == $past(xd_i.addr))
		else $error("data move read not sent to ram");
	a_ram_cause: assert property (ram_o.req |-> $past(xd_req_i))
		else $error("ram access without a request");
	a_fault_hold: assert property (fault_reset_o |=> fault_reset_o)
		else $error("fault reset request dropped");
	a_fault_idle: assert property ($rose(fault_reset_o) |-> !cpu_stall_o)
		else $error("faulty write started an operation");
	a_code_read: assert property (code_rd_i && !cpu_stall_o
		|=> code_valid_o) else $error("code read not answered");
endmodule // fwes_monitor

// ### sim/fwes_top_tb.sv
// self-checking bench for the flash write/erase sequencer
`timescale 1ns/1ns
module fwes_top_tb;
	logic                clk_i = 0, rst_i = 1, por_i = 1, go = 0, rq;
	logic                wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]          wb_adr_i = 8'h00, code_rdata_o, d1, d2;
	logic [3:0]          wb_sel_i = 4'hF;
	logic [31:0]         wb_dat_i = 32'h0, wb_dat_o, q;
	logic                wb_ack_o, xd_req_i, cpu_stall_o, code_rd_i = 0;
	logic                code_fetch_i = 0, code_valid_o, dbg_req_i = 0;
	logic                dbg_done_o, fault_reset_o;
	logic [15:0]         code_addr_i = 16'h0000, a, b, c;
	fwes_pkg::fwes_xd_s  xd_i, cmd = '0;
	fwes_pkg::fwes_ram_s ram_o;
	fwes_pkg::fwes_dbg_s dbg_i = '0;
	int                  err_total = 0, num_checks = 0, n;

	always #2 clk_i = ~clk_i;

	fwes_top DUT (.clk_i, .rst_i, .por_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .xd_req_i,
		.xd_i, .ram_o, .cpu_stall_o, .code_rd_i, .code_fetch_i,
		.code_addr_i, .code_rdata_o, .code_valid_o, .dbg_req_i, .dbg_i,
		.dbg_done_o, .fault_reset_o);
	fwes_core_model u_core (.clk_i, .cpu_stall_i(cpu_stall_o), .go_i(go),
		.cmd_i(cmd), .xd_req_o(xd_req_i), .xd_o(xd_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] dt);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= {24'h000000, dt};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++k < 20);
		if (wb_ack_o !== 1'b1)
			err_total++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		wb(1'b0, ad, 8'h00);
		chk(q, e);
	endtask

	task automatic unlock;
		wb(1'b1, fwes_pkg::KEY_OFS, fwes_pkg::KEY_FIRST);
		wb(1'b1, fwes_pkg::KEY_OFS, fwes_pkg::KEY_SECOND);
	endtask

	// core move: rq is the ram strobe, n the stall length in cycles
	task automatic xd(input logic w, input logic s, input logic [15:0] ad,
		input logic [7:0] dt);
		@(posedge clk_i);
		cmd <= '{w, s, ad, dt};
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (3) @(posedge clk_i);
		rq = ram_o.req;
		n = 0;
		while (cpu_stall_o === 1'b1 && n < 1100) begin
			n++;
			@(posedge clk_i);
		end
	endtask

	task automatic cr(input logic [15:0] ad, input logic [7:0] e);
		@(posedge clk_i);
		code_rd_i <= 1'b1;
		code_addr_i <= ad;
		@(posedge clk_i);
		code_rd_i <= 1'b0;
		@(posedge clk_i);
		chk(code_rdata_o, e);
	endtask

	// debug port request; n counts cycles until the done pulse
	task automatic dbg(input logic e, input logic [15:0] ad,
		input logic [7:0] dt);
		@(posedge clk_i);
		dbg_i <= '{e, ad, dt};
		dbg_req_i <= 1'b1;
		@(posedge clk_i);
		dbg_req_i <= 1'b0;
		n = 0;
		while (dbg_done_o !== 1'b1 && n < 1100) begin
			n++;
			@(posedge clk_i);
		end
	endtask

	task automatic rst(input logic p);
		@(posedge clk_i);
		if (p)
			por_i <= 1'b1;
		else
			rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		por_i <= 1'b0;
		rst_i <= 1'b0;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#100000;
		err_total++;
		test_done;
	end

	initial begin
		void'($urandom(6507));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		rd(fwes_pkg::SUPPLY_OFS, 32'h3);
		rd(fwes_pkg::PSC_OFS, 32'h0);
		rd(8'h14, fwes_pkg::RDATA_UNMAPPED);
		unlock;
		rd(fwes_pkg::KEY_OFS, 32'h2);
		wb(1'b1, fwes_pkg::PSC_OFS, 8'h03);
		xd(1'b1, 1'b0, 16'($urandom) & 16'h03FF, 8'($urandom));
		chk(n, fwes_pkg::PAGE_BYTES);
		rd(fwes_pkg::KEY_OFS, 32'h0);
		rd(fwes_pkg::PSC_OFS, 32'h3);
		cr(16'($urandom) & 16'h03FF, fwes_pkg::ERASED_BYTE);
		wb(1'b1, fwes_pkg::PSC_OFS, 8'h01);
		a = 16'h0100 | (16'($urandom) & 16'h02FF);
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		unlock;
		xd(1'b1, 1'b0, a, d1);
		chk(n, fwes_pkg::PROG_CYCLES);
		cr(a, d1);
		unlock;
		xd(1'b1, 1'b0, a, d2);
		cr(a, d1 & d2);
		unlock;
		xd(1'b1, 1'b1, 16'hAB55, d2);
		cr(16'h0055, d2);
		xd(1'b0, 1'b0, a, 8'h00);
		chk(rq, 1'b1);
		wb(1'b1, fwes_pkg::PSC_OFS, 8'h00);
		xd(1'b1, 1'b0, a, 8'h00);
		chk(rq, 1'b1);
		rd(fwes_pkg::KEY_OFS, 32'h0);
		wb(1'b1, fwes_pkg::PSC_OFS, 8'h01);
		xd(1'b1, 1'b0, a, 8'h00);
		rd(fwes_pkg::KEY_OFS, 32'h3);
		unlock;
		xd(1'b1, 1'b0, a, 8'h00);
		cr(a, d1 & d2);
		rst(1'b0);
		rd(fwes_pkg::RSRC_OFS, 32'h0);
		wb(1'b1, fwes_pkg::KEY_OFS, fwes_pkg::KEY_SECOND);
		rd(fwes_pkg::KEY_OFS, 32'h3);
		rst(1'b0);
		wb(1'b1, fwes_pkg::SUPPLY_OFS, 8'h01);
		wb(1'b1, fwes_pkg::PSC_OFS, 8'h01);
		unlock;
		xd(1'b1, 1'b0, a, 8'h00);
		chk(fault_reset_o, 1'b1);
		rst(1'b0);
		rd(fwes_pkg::RSRC_OFS, 32'h1);
		cr(a, d1 & d2);
		rst(1'b1);
		rd(fwes_pkg::SUPPLY_OFS, 32'h3);
		b = 16'h0080 | (16'($urandom) & 16'h003F);
		c = 16'h0040 | (16'($urandom) & 16'h000F);
		dbg(1'b0, b, d1);
		chk(n, fwes_pkg::PROG_CYCLES + 1);
		cr(b, d1);
		wb(1'b1, fwes_pkg::PSC_OFS, 8'h07);
		unlock;
		xd(1'b1, 1'b0, 16'h0200, 8'h00);
		chk(n, fwes_pkg::PAGE_BYTES);
		wb(1'b1, fwes_pkg::PSC_OFS, 8'h05);
		unlock;
		xd(1'b1, 1'b0, c, 8'h5A);
		cr(c, 8'h5A);
		code_fetch_i <= 1'b1;
		cr(c, fwes_pkg::ERASED_BYTE);
		cr(16'h0055, d2);
		code_fetch_i <= 1'b0;
		test_done;
	end
endmodule // fwes_top_tb

bind fwes_top fwes_monitor u_mon (.clk_i, .rst_i, .por_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .xd_req_i, .xd_i, .ram_o, .cpu_stall_o,
	.code_rd_i, .code_valid_o, .dbg_req_i, .fault_reset_o);
